// ===== common/diqc_pkg.sv
// Shared constants, register map and carrier types of the interrupt queues
package diqc_pkg;

	// ***************************************************************
	// Sizes
	// ***************************************************************
	localparam int DIQC_NQ      = 10;  // Circular queues in host memory
	localparam int DIQC_NSLOT   = 8;   // Channel slots: 4 receive, 4 transmit
	localparam int DIQC_FDEPTH  = 16;  // Central vector FIFO, DWORDs
	localparam int DIQC_FAW     = 4;   // FIFO pointer width
	localparam int DIQC_IDXW    = 11;  // Queue write index width
	localparam int DIQC_LENW    = 6;   // Length field, units of 32 DWORDs
	localparam int DIQC_LEN_LOW = 5;   // Index bits below the length unit

	// ***************************************************************
	// Register byte offsets
	// ***************************************************************
	localparam logic [7:0] DIQC_OFS_STATUS  = 8'h00;
	localparam logic [7:0] DIQC_OFS_LEN0    = 8'h04;
	localparam logic [7:0] DIQC_OFS_LEN1    = 8'h08;
	localparam logic [7:0] DIQC_OFS_DMASK   = 8'h0c;
	localparam logic [7:0] DIQC_OFS_EMASK   = 8'h10;
	localparam logic [7:0] DIQC_OFS_CTRL    = 8'h14;
	localparam logic [1:0] DIQC_BASE_REGION = 2'h1;  // 0x40 + 4*queue
	localparam logic [2:0] DIQC_LAST_REGION = 3'h4;  // 0x80 + 4*slot

	// ***************************************************************
	// Reset values and fields
	// ***************************************************************
	localparam logic [31:0] DIQC_RST_WORD  = 32'h0000_0000;
	localparam int          DIQC_CTRL_LDA  = 0;   // Last-address hold mode
	localparam int          DIQC_VEC_ERR   = 0;   // Error indication bit
	localparam int          DIQC_VEC_FI    = 1;   // Frame indication bit
	localparam int          DIQC_VEC_HI    = 2;   // Host-initiated bit
	localparam int          DIQC_VEC_SRC   = 28;  // Source id, bits 31:28

	// ***************************************************************
	// Source identifiers and queue numbers
	// ***************************************************************
	localparam logic [3:0] DIQC_SRC_DMA    = 4'h8;
	localparam logic [3:0] DIQC_SRC_GPP    = 4'h9;
	localparam logic [3:0] DIQC_SRC_SSB    = 4'ha;
	localparam logic [3:0] DIQC_SRC_LBB    = 4'hb;
	localparam logic [3:0] DIQC_Q_CFG      = 4'h8;
	localparam logic [3:0] DIQC_Q_PERIPH   = 4'h9;

	// Descriptor completion report from one DMA channel slot
	typedef struct packed {
		logic        host_request_flag;
		logic        frame_end_flag;
		logic        hold;
		logic        no_fit;
		logic        abort_started;
		logic        count_zero;
		logic [31:0] cur_addr;
	} diqc_desc_t;

	// Host memory write of one vector
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} diqc_mem_t;

endpackage

// ===== hdl/diqc_top.sv
// Interrupt queue controller: vector FIFO, queue writer, status and INTA
// Functional notes
// - Sixteen-DWORD FIFO buffers all 32-bit vectors
// - Source id selects one of ten queues
// - Per-queue status bit set, host writes one
// - INTA held while any status bit pending
// - Base per queue, lengths in 32-DWORD steps
// - Separate receive and transmit queue per channel
// - DMA vectors to config, peripherals to peripheral
// - Masked source gives no vector, status, INTA
// - Six descriptor interrupts per channel generated
// - Host-request flag gives host-initiated vector
// - Frame-end flag gives frame indication vector
// - Receive overfill under hold raises error
// - Receive reset aborting transfer raises error
// - Two transmit descriptor cases raise error
// - Processing continues after any error
// - Frame and host indications share one vector
// - All-ones write clears every status bit except one set in that cycle
// - Every unmasked event sets status and INTA
// - Last-address match acts as hold
//
// Decided for this implementation: the address map and strobed register access.
module diqc_top
	import diqc_pkg::*;
(
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// Register port
	input  wire logic [7:0]             reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [31:0]            reg_rdata,
	// Vectors from serial channels and peripheral blocks
	input  wire logic                   ext_valid,
	input  wire logic [31:0]            ext_vector,
	output logic                        ext_ready,
	// Descriptor completion reports
	input  wire logic                   desc_valid,
	input  wire logic [2:0]             desc_slot,
	input  wire diqc_pkg::diqc_desc_t   desc_info,
	output logic                        desc_ready,
	// Host memory writer
	output logic                        mem_valid,
	output diqc_pkg::diqc_mem_t         mem_req,
	input  wire logic                   mem_ready,
	// PCI interrupt line
	output logic                        inta_n
);

	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic [31:0]             fifo_mem [DIQC_FDEPTH];
	logic [DIQC_FAW-1:0]     rd_ptr;
	logic [DIQC_FAW-1:0]     wr_ptr;
	logic [DIQC_FAW:0]       fifo_cnt;
	logic                    fifo_full;
	logic                    fifo_empty;
	logic                    fifo_push;
	logic                    fifo_pop;
	logic [31:0]             push_word;
	logic                    desc_hv;
	logic [31:0]             desc_vec;
	logic                    ext_hv;
	logic [31:0]             ext_vec;
	logic                    next_desc_hv;
	logic                    next_ext_hv;
	logic [2:0]              dflags;
	logic                    hold_cond;
	logic                    derr;
	logic [DIQC_NQ-1:0]      status;
	logic [DIQC_NQ-1:0]      next_status;
	logic [DIQC_NQ-1:0]      set_bits;
	logic [DIQC_NQ-1:0]      clr_bits;
	logic [31:0]             len0;
	logic [31:0]             len1;
	logic [31:0]             dmask;
	logic [31:0]             emask;
	logic [31:0]             ctrl;
	logic [31:0]             qbase [DIQC_NQ];
	logic [31:0]             last_addr [DIQC_NSLOT];
	logic [DIQC_IDXW-1:0]    widx [DIQC_NQ];
	logic [3:0]              mem_q;
	logic [3:0]              head_q;
	logic                    mem_done;
	logic                    base_hit;
	logic                    last_hit;
	logic [3:0]              base_sel;
	logic [2:0]              last_sel;

	// ***************************************************************
	// Helper functions
	// ***************************************************************

	// Queue chosen by the source id of a vector
	function automatic logic [3:0] queue_of(input logic [31:0] v);
		logic [3:0] id;
		id = v[DIQC_VEC_SRC+:4];
		if (id < DIQC_SRC_DMA)
			queue_of = id;
		else if (id >= DIQC_SRC_GPP && id <= DIQC_SRC_LBB)
			queue_of = DIQC_Q_PERIPH;
		else
			queue_of = DIQC_Q_CFG;
	endfunction

	// Last index of a queue: (field + 1) * 32 - 1
	function automatic logic [DIQC_IDXW-1:0] last_idx(input logic [3:0] q);
		logic [DIQC_LENW-1:0] f;
		f = '0;
		for (int i = 0; i < DIQC_NQ; i++)
		begin
			if (q == 4'(i))
				f = (i < 5) ? len0[i*DIQC_LENW+:DIQC_LENW]
				            : len1[(i-5)*DIQC_LENW+:DIQC_LENW];
		end
		last_idx = {f, {DIQC_LEN_LOW{1'b1}}};
	endfunction

	// ***************************************************************
	// Descriptor interrupt generation
	// ***************************************************************

	// Hold is the descriptor flag, or the last-address match when LDA is set
	always_comb
	begin
		if (ctrl[DIQC_CTRL_LDA])
			hold_cond = desc_info.cur_addr == last_addr[desc_slot];
		else
			hold_cond = desc_info.hold;
		if (!desc_slot[2])
			derr = (desc_info.no_fit && hold_cond)
			    || desc_info.abort_started;
		else
			derr = (hold_cond && !desc_info.frame_end_flag)
			    || (!desc_info.frame_end_flag && desc_info.count_zero);
		dflags[DIQC_VEC_HI]  = desc_info.host_request_flag;
		dflags[DIQC_VEC_FI]  = desc_info.frame_end_flag;
		dflags[DIQC_VEC_ERR] = derr;
		dflags = dflags & ~dmask[desc_slot*3+:3];
	end

	// Holding register for one descriptor vector
	always_ff @(posedge mclk)
	begin
		if (rst)
			desc_vec <= DIQC_RST_WORD;
		else if (desc_valid && desc_ready)
			desc_vec <= {1'b0, desc_slot, 25'h0, dflags};
	end

	// Holding register for one external vector
	always_ff @(posedge mclk)
	begin
		if (rst)
			ext_vec <= DIQC_RST_WORD;
		else if (ext_valid && ext_ready)
			ext_vec <= ext_vector;
	end

	// Hold occupancy; a fully masked event is accepted and dropped
	always_comb
	begin
		next_desc_hv = (desc_hv && !fifo_push)
		            || (desc_valid && desc_ready && |dflags);
		next_ext_hv = (ext_hv && !(fifo_push && !desc_hv))
		           || (ext_valid && ext_ready
		               && !emask[ext_vector[DIQC_VEC_SRC+:4]]);
	end

	// Producers stall while their holding register is occupied
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			desc_hv    <= 1'b0;
			ext_hv     <= 1'b0;
			desc_ready <= 1'b0;
			ext_ready  <= 1'b0;
		end
		else
		begin
			desc_hv    <= next_desc_hv;
			ext_hv     <= next_ext_hv;
			desc_ready <= !next_desc_hv;
			ext_ready  <= !next_ext_hv;
		end
	end

	// ***************************************************************
	// Central vector FIFO
	// ***************************************************************

	// Descriptor vectors win the single write per cycle
	assign fifo_full  = fifo_cnt == (DIQC_FAW+1)'(DIQC_FDEPTH);
	assign fifo_empty = fifo_cnt == '0;
	assign fifo_push  = (desc_hv || ext_hv) && !fifo_full;
	assign push_word  = desc_hv ? desc_vec : ext_vec;
	assign fifo_pop   = !fifo_empty && (!mem_valid || mem_ready);
	assign head_q     = queue_of(fifo_mem[rd_ptr]);

	// Storage
	always_ff @(posedge mclk)
	begin
		if (fifo_push)
			fifo_mem[wr_ptr] <= push_word;
	end

	// Pointers and fill count
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			fifo_cnt <= '0;
		end
		else
		begin
			if (fifo_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (fifo_pop)
				rd_ptr <= rd_ptr + 1'b1;
			case ({fifo_push, fifo_pop})
				2'b10:   fifo_cnt <= fifo_cnt + 1'b1;
				2'b01:   fifo_cnt <= fifo_cnt - 1'b1;
				default: fifo_cnt <= fifo_cnt;
			endcase
		end
	end

	// ***************************************************************
	// Queue writer
	// ***************************************************************

	// One outstanding memory write holding the head vector
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mem_valid <= 1'b0;
			mem_req   <= '0;
			mem_q     <= '0;
		end
		else if (fifo_pop)
		begin
			mem_valid    <= 1'b1;
			mem_q        <= head_q;
			mem_req.data <= fifo_mem[rd_ptr];
			mem_req.addr <= qbase[head_q]
			              + {19'h0, widx[head_q], 2'b00};
		end
		else if (mem_ready)
			mem_valid <= 1'b0;
	end

	assign mem_done = mem_valid && mem_ready;

	// Per-queue base register and write index
	genvar gq;
	generate
		for (gq = 0; gq < DIQC_NQ; gq++)
		begin : g_queue
			always_ff @(posedge mclk)
			begin
				if (rst)
					qbase[gq] <= DIQC_RST_WORD;
				else if (reg_wr && base_hit && base_sel == 4'(gq))
					qbase[gq] <= reg_wdata;
			end
			always_ff @(posedge mclk)
			begin
				if (rst)
					widx[gq] <= '0;
				else if (fifo_pop && head_q == 4'(gq))
				begin
					if (widx[gq] >= last_idx(4'(gq)))
						widx[gq] <= '0;
					else
						widx[gq] <= widx[gq] + 1'b1;
				end
			end
		end
	endgenerate

	// ***************************************************************
	// Queue status and interrupt line
	// ***************************************************************

	// A vector landing in memory sets its bit; set beats clear
	always_comb
	begin
		set_bits = '0;
		if (mem_done)
			set_bits[mem_q] = 1'b1;
		clr_bits = '0;
		if (reg_wr && reg_addr == DIQC_OFS_STATUS)
			clr_bits = reg_wdata[DIQC_NQ-1:0];
		next_status = (status & ~clr_bits) | set_bits;
	end

	// Status bits and INTA, low while anything is pending
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			status <= '0;
			inta_n <= 1'b1;
		end
		else
		begin
			status <= next_status;
			inta_n <= ~|next_status;
		end
	end

	// ***************************************************************
	// Register port
	// ***************************************************************

	// Decode of the indexed regions
	assign base_hit = reg_addr[7:6] == DIQC_BASE_REGION
	               && reg_addr[1:0] == 2'b00
	               && reg_addr[5:2] < 4'(DIQC_NQ);
	assign base_sel = reg_addr[5:2];
	assign last_hit = reg_addr[7:5] == DIQC_LAST_REGION
	               && reg_addr[1:0] == 2'b00;
	assign last_sel = reg_addr[4:2];

	// Single configuration registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			len0  <= DIQC_RST_WORD;
			len1  <= DIQC_RST_WORD;
			dmask <= DIQC_RST_WORD;
			emask <= DIQC_RST_WORD;
			ctrl  <= DIQC_RST_WORD;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				DIQC_OFS_LEN0:  len0  <= reg_wdata;
				DIQC_OFS_LEN1:  len1  <= reg_wdata;
				DIQC_OFS_DMASK: dmask <= reg_wdata;
				DIQC_OFS_EMASK: emask <= reg_wdata;
				DIQC_OFS_CTRL:  ctrl  <= reg_wdata;
				default:        ctrl  <= ctrl;
			endcase
		end
	end

	// Last descriptor address per channel slot
	genvar gs;
	generate
		for (gs = 0; gs < DIQC_NSLOT; gs++)
		begin : g_slot
			always_ff @(posedge mclk)
			begin
				if (rst)
					last_addr[gs] <= DIQC_RST_WORD;
				else if (reg_wr && last_hit && last_sel == 3'(gs))
					last_addr[gs] <= reg_wdata;
			end
		end
	endgenerate

	// Read data one cycle after the strobe, zero when unmapped
	always_ff @(posedge mclk)
	begin
		if (rst)
			reg_rdata <= DIQC_RST_WORD;
		else if (reg_rd)
		begin
			if (base_hit)
				reg_rdata <= qbase[base_sel];
			else if (last_hit)
				reg_rdata <= last_addr[last_sel];
			else
			begin
				case (reg_addr)
					DIQC_OFS_STATUS: reg_rdata <= {22'h0, status};
					DIQC_OFS_LEN0:   reg_rdata <= len0;
					DIQC_OFS_LEN1:   reg_rdata <= len1;
					DIQC_OFS_DMASK:  reg_rdata <= dmask;
					DIQC_OFS_EMASK:  reg_rdata <= emask;
					DIQC_OFS_CTRL:   reg_rdata <= ctrl;
					default:         reg_rdata <= DIQC_RST_WORD;
				endcase
			end
		end
		else
			reg_rdata <= DIQC_RST_WORD;
	end

endmodule

// ===== sim/diqc_host_mem.sv
// Host memory model that accepts vector writes promptly or slowly
module diqc_host_mem
	import diqc_pkg::*;
(
	// Clock, reset and pacing
	input  logic                mclk,
	input  logic                rst,
	input  logic                stall,
	input  logic                slow,
	// Vector write port
	input  logic                mem_valid,
	input  diqc_pkg::diqc_mem_t mem_req,
	output logic                mem_ready,
	// Record of accepted writes
	output int                  wr_count,
	output logic [31:0]         last_addr,
	output logic [31:0]         last_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Ready every cycle, every other cycle when slow, never when stalled
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mem_ready <= 1'b0;
			wr_count  <= 0;
		end
		else
		begin
			mem_ready <= !stall && !(slow && mem_ready);
			if (mem_valid && mem_ready)
			begin
				wr_count  <= wr_count + 1;
				last_addr <= mem_req.addr;
				last_data <= mem_req.data;
			end
		end
	end
endmodule

// ===== sim/diqc_top_assertions.sv
// Port checker of the interrupt queue controller and its bind
module diqc_chk
	import diqc_pkg::*;
(
	// Clock and reset
	input logic                mclk,
	input logic                rst,
	// Register port
	input logic [7:0]          reg_addr,
	input logic [31:0]         reg_wdata,
	input logic                reg_wr,
	input logic                reg_rd,
	input logic [31:0]         reg_rdata,
	// Producers
	input logic                ext_valid,
	input logic [31:0]         ext_vector,
	input logic                ext_ready,
	input logic                desc_valid,
	input logic [2:0]          desc_slot,
	input diqc_pkg::diqc_desc_t desc_info,
	input logic                desc_ready,
	// Memory writer and interrupt line
	input logic                mem_valid,
	input diqc_pkg::diqc_mem_t mem_req,
	input logic                mem_ready,
	input logic                inta_n
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ***************************************************************
	// Checks
	// ***************************************************************
	// A descriptor report taken and kept for the FIFO
	sequence desc_kept;
		desc_valid && desc_ready ##1 !desc_ready;
	endsequence

	inta_set_a: assert property (mem_valid && mem_ready |=> !inta_n)
		else $error("line not raised after vector write");
	inta_keep_a: assert property (!inta_n && !reg_wr |=> !inta_n)
		else $error("line released without a clear");
	clr_all_a: assert property (reg_wr && reg_addr == 8'h00 &&
		reg_wdata == 32'hffffffff && !(mem_valid && mem_ready) |=> inta_n)
		else $error("all-ones clear left line low");
	mem_hold_a: assert property (mem_valid && !mem_ready |=>
		mem_valid && $stable(mem_req))
		else $error("memory request dropped or changed");
	addr_align_a: assert property (mem_valid |-> mem_req.addr[1:0] == 2'h0)
		else $error("vector address not aligned");
	vec_nz_a: assert property (mem_valid |-> mem_req.data != 32'h0)
		else $error("empty vector written");
	desc_fifo_a: assert property (desc_kept |-> ##[0:3] mem_valid)
		else $error("kept report never reached memory");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule

bind diqc_top diqc_chk diqc_chk_i (.mclk(mclk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_valid(ext_valid),
	.ext_vector(ext_vector), .ext_ready(ext_ready),
	.desc_valid(desc_valid), .desc_slot(desc_slot),
	.desc_info(desc_info), .desc_ready(desc_ready),
	.mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
	.inta_n(inta_n));

// ===== sim/testbench.sv
// Self-checking bench of the interrupt queue controller
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import diqc_pkg::*;
	logic        mclk, rst, reg_wr, reg_rd, ext_valid, desc_valid;
	logic        stall, slow, ext_ready, desc_ready, mem_valid;
	logic        mem_ready, inta_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, ext_vector, reg_rdata, rdv;
	logic [31:0] last_addr, last_data;
	logic [2:0]  desc_slot;
	diqc_desc_t  desc_info;
	diqc_mem_t   mem_req;
	int          errors, check_count, cycles, taken, wr_count;
	int          idx [10];

	diqc_top diqc_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_valid(ext_valid),
		.ext_vector(ext_vector), .ext_ready(ext_ready),
		.desc_valid(desc_valid), .desc_slot(desc_slot),
		.desc_info(desc_info), .desc_ready(desc_ready),
		.mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
		.inta_n(inta_n));
	diqc_host_mem diqc_host_mem_i (.mclk(mclk), .rst(rst), .stall(stall),
		.slow(slow), .mem_valid(mem_valid), .mem_req(mem_req),
		.mem_ready(mem_ready), .wr_count(wr_count),
		.last_addr(last_addr), .last_data(last_data));

	// Clock and hang guard
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			final_report;
		end
	end

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function logic [31:0] base(input int q);
		return 32'h0001_0000 + 32'(q << 8);
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Offer one vector or report and hold it until taken
	task send(input bit d, input logic [2:0] s, input logic [5:0] b,
		input logic [31:0] v);
		@(posedge mclk);
		desc_valid <= d;
		ext_valid  <= !d;
		desc_slot  <= s;
		desc_info  <= diqc_desc_t'({b, v});
		ext_vector <= v;
		#1;
		while ((d ? desc_ready : ext_ready) !== 1'b1)
		begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		desc_valid <= 1'b0;
		ext_valid  <= 1'b0;
		taken++;
	endtask
	// Wait for one memory write and judge where and what it wrote
	task exp_mem(input int q, input logic [31:0] v);
		int n;
		n = wr_count;
		repeat (60) if (wr_count == n) @(posedge mclk);
		chk(last_addr, base(q) + 32'(4 * idx[q]));
		chk(last_data, v);
		chk(32'(last_data != 32'h0), 32'h1);
		idx[q] = (idx[q] + 1) % 32;
	endtask
	// Report from slot s; zero v means no vector may appear
	task dv(input logic [2:0] s, input logic [5:0] b, input logic [31:0] a,
		input logic [31:0] v);
		int n;
		n = wr_count;
		send(1'b1, s, b, a);
		if (v != 32'h0)
			exp_mem(int'(s), v);
		else
		begin
			repeat (12) @(posedge mclk);
			chk(32'(wr_count), 32'(n));
		end
	endtask

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task t_regs;
		rdchk(DIQC_OFS_STATUS, 32'h0);
		rdchk(DIQC_OFS_LEN0, 32'h0);
		wr(8'h3c, 32'hffffffff);
		rdchk(8'h3c, 32'h0);
		for (int q = 0; q < 10; q++)
			wr(8'h40 + 8'(4 * q), base(q));
		rdchk(8'h64, base(9));
		$display("test regs done");
	endtask
	task t_desc;
		slow <= 1'b1;
		dv(3'h0, 6'b110000, 32'h0, 32'h0000_0006);
		rdchk(DIQC_OFS_STATUS, 32'h1);
		chk(32'(inta_n), 32'h0);
		wr(DIQC_OFS_STATUS, 32'h1);
		rdchk(DIQC_OFS_STATUS, 32'h0);
		chk(32'(inta_n), 32'h1);
		dv(3'h4, 6'b100000, 32'h0, 32'h4000_0004);
		dv(3'h4, 6'b010000, 32'h0, 32'h4000_0002);
		slow <= 1'b0;
		$display("test desc done");
	endtask
	task t_err;
		dv(3'h1, 6'b001100, 32'h0, 32'h1000_0001);
		dv(3'h1, 6'b000100, 32'h0, 32'h0);
		dv(3'h2, 6'b000010, 32'h0, 32'h2000_0001);
		dv(3'h5, 6'b001000, 32'h0, 32'h5000_0001);
		dv(3'h5, 6'b011000, 32'h0, 32'h5000_0002);
		dv(3'h6, 6'b000001, 32'h0, 32'h6000_0001);
		wr(DIQC_OFS_CTRL, 32'h1);
		wr(8'h9c, 32'h2000);
		dv(3'h7, 6'b000000, 32'h2000, 32'h7000_0001);
		dv(3'h7, 6'b001000, 32'h2004, 32'h0);
		dv(3'h3, 6'b000100, 32'h0, 32'h3000_0001);
		wr(DIQC_OFS_CTRL, 32'h0);
		$display("test err done");
	endtask
	task t_route;
		send(1'b0, 3'h0, 6'h0, 32'h8000_0011);
		exp_mem(8, 32'h8000_0011);
		for (int i = 9; i < 12; i++)
		begin
			send(1'b0, 3'h0, 6'h0, 32'(i) << 28 | 32'h1);
			exp_mem(9, 32'(i) << 28 | 32'h1);
		end
		send(1'b0, 3'h0, 6'h0, 32'hc000_0001);
		exp_mem(8, 32'hc000_0001);
		wr(DIQC_OFS_STATUS, 32'hffffffff);
		wr(DIQC_OFS_EMASK, 32'h400);
		send(1'b0, 3'h0, 6'h0, 32'ha000_0005);
		wr(DIQC_OFS_DMASK, 32'h7);
		dv(3'h0, 6'b110000, 32'h0, 32'h0);
		rdchk(DIQC_OFS_STATUS, 32'h0);
		chk(32'(inta_n), 32'h1);
		wr(DIQC_OFS_DMASK, 32'h2);
		dv(3'h0, 6'b110000, 32'h0, 32'h0000_0004);
		wr(DIQC_OFS_DMASK, 32'h0);
		$display("test route done");
	endtask
	task t_stall;
		int n, k;
		n = wr_count;
		stall <= 1'b1;
		taken = 0;
		fork
			for (int i = 0; i < 33; i++)
				send(1'b0, 3'h0, 6'h0, 32'h2000_0001 + 32'(i));
			begin
				repeat (100) @(posedge mclk);
				stall <= 1'b0;
				#1;
				chk(32'(taken), 32'd18);
				chk(32'(ext_ready), 32'h0);
			end
		join
		repeat (200) if (wr_count != n + 33) @(posedge mclk);
		chk(32'(wr_count), 32'(n + 33));
		k = (idx[2] + 32) % 32;
		chk(last_addr, base(2) + 32'(4 * k));
		idx[2] = (k + 1) % 32;
		wr(DIQC_OFS_STATUS, 32'hffffffff);
		rdchk(DIQC_OFS_STATUS, 32'h0);
		chk(32'(inta_n), 32'h1);
		$display("test stall done");
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rst, reg_wr, reg_rd, ext_valid, desc_valid, stall, slow} = 7'h40;
		{reg_addr, reg_wdata, ext_vector, desc_slot} = '0;
		desc_info = '0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_desc;
		t_err;
		t_route;
		t_stall;
		final_report;
	end
endmodule
